// *** rtl/fcl_loader.sv ***
// Fuse configuration loader: latches fuse bytes at reset, decodes them.
// Assumes fuse storage values are stable while reset is applied.
// Function
// - Brown-out fields reload on power-on reset, or on any reset while not yet loaded
// - Fuse bits 7:5 give threshold level
// - Fuse bit 4 gives sample rate
// - Fuse bits 3:2 give active mode
// - Fuse bits 1:0 give sleep mode
// - Lock bit blocks calibration writes
// - Frequency select picks 16 or 20 MHz
// - Frequency select picks factory calibration values
// - Bits 7:6 select CRC scan range
// - Bits 3:2 select reset pin function
// - GPIO driver off 768 slow cycles
// - Preserve bit keeps EEPROM on erase
// - Locked device always erases EEPROM
// - Start-up code selects 0 to 64 ms
// - Application end counts 256-byte blocks
// - Flash above application end is data
// - Application end zero makes rest code
// - Boot end zero makes whole flash boot
// - Both zero means all boot
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module fcl_loader #(
  parameter int FLASH_BLOCKS = 64,
  parameter int HOLD_TICKS   = fcl_pkg::PIN_HOLD,
  parameter int SLOW_DIV     = fcl_pkg::SLOW_DIV,
  parameter int MS_CYC       = fcl_pkg::MS_CYCLES
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        por_i,
  input  wire logic [7:0]  fuse_bod_i,
  input  wire logic [7:0]  fuse_osc_i,
  input  wire logic [7:0]  fuse_sysa_i,
  input  wire logic [7:0]  fuse_sysb_i,
  input  wire logic [7:0]  fuse_appe_i,
  input  wire logic [7:0]  fuse_boote_i,
  input  wire logic [7:0]  cal16_freq_i,
  input  wire logic [7:0]  cal16_temp_i,
  input  wire logic [7:0]  cal20_freq_i,
  input  wire logic [7:0]  cal20_temp_i,
  input  wire logic        device_locked_i,
  input  wire logic [7:0]  flash_block_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [2:0]       threshold_level_o,
  output logic             sample_rate_select_o,
  output logic [1:0]       bod_active_mode_o,
  output logic [1:0]       bod_sleep_mode_o,
  output logic             calibration_lock_o,
  output logic             osc_20m_select_o,
  output logic [7:0]       main_osc_frequency_cal_o,
  output logic [7:0]       main_osc_temperature_cal_o,
  output logic [1:0]       crc_scan_source_o,
  output logic [1:0]       reset_pin_function_o,
  output logic             gpio_driver_enable_o,
  output logic             erase_eeprom_o,
  output logic             startup_done_o,
  output logic             flash_is_boot_o,
  output logic             flash_is_app_code_o,
  output logic             flash_is_app_data_o
);
  initial begin
    if (FLASH_BLOCKS < 1 || FLASH_BLOCKS > 256) $error("FLASH_BLOCKS out of range");
    if (HOLD_TICKS < 1 || HOLD_TICKS > 1023) $error("HOLD_TICKS out of range");
  end

  typedef enum logic [1:0] {ST_LOAD, ST_RUN} fcl_state_t;
  typedef struct packed {
    fcl_state_t  st;
    logic [7:0]  bod;
    logic [7:0]  osc;
    logic [7:0]  sysa;
    logic [7:0]  sysb;
    logic [7:0]  appe;
    logic [7:0]  boote;
    logic [7:0]  fcal;
    logic [7:0]  tcal;
    logic [9:0]  hold;
    logic        bod_valid;
    logic        start;
    logic        ack;
    logic [31:0] rdata;
  } fcl_regs_t;

  fcl_regs_t r_ff;
  fcl_regs_t nxt_r;
  logic      tick;
  logic      apb_acc;
  logic [3:0] idx;
  logic [1:0] fsel_safe;
  logic [1:0] pin_safe;
  logic [8:0] blk;

  fcl_slow_tick #(.DIV(SLOW_DIV)) u_tick (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .tick_o    (tick)
  );

  fcl_startup #(.MS_CYC(MS_CYC)) u_sut (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .start_i   (r_ff.start),
    .sel_i     (r_ff.sysb[fcl_pkg::SUT_HI:fcl_pkg::SUT_LO]),
    .done_o    (startup_done_o)
  );

  function automatic logic [1:0] safe_fsel(input logic [1:0] c);
    safe_fsel = (c == fcl_pkg::FSEL_16M) ? fcl_pkg::FSEL_16M : fcl_pkg::FSEL_20M;
  endfunction
  function automatic logic [1:0] safe_pin(input logic [1:0] c);
    safe_pin = (c == 2'h3) ? fcl_pkg::PIN_RESET : c;
  endfunction

  assign fsel_safe = safe_fsel(r_ff.osc[fcl_pkg::FSEL_HI:fcl_pkg::FSEL_LO]);
  assign pin_safe  = safe_pin(r_ff.sysa[fcl_pkg::PIN_HI:fcl_pkg::PIN_LO]);
  assign apb_acc   = psel && penable;
  assign idx       = paddr[5:2];
  assign blk       = {1'b0, flash_block_i};

  always_comb begin
    nxt_r       = r_ff;
    nxt_r.start = 1'b0;
    nxt_r.ack   = 1'b0;
    unique case (r_ff.st)
      ST_LOAD: begin
        nxt_r.osc   = fuse_osc_i;
        nxt_r.sysa  = fuse_sysa_i;
        nxt_r.sysb  = fuse_sysb_i;
        nxt_r.appe  = fuse_appe_i;
        nxt_r.boote = fuse_boote_i;
        if (por_i || !r_ff.bod_valid) begin
          nxt_r.bod       = fuse_bod_i;
          nxt_r.bod_valid = 1'b1;
        end
        if (safe_fsel(fuse_osc_i[fcl_pkg::FSEL_HI:fcl_pkg::FSEL_LO]) == fcl_pkg::FSEL_16M) begin
          nxt_r.fcal = cal16_freq_i;
          nxt_r.tcal = cal16_temp_i;
        end else begin
          nxt_r.fcal = cal20_freq_i;
          nxt_r.tcal = cal20_temp_i;
        end
        nxt_r.hold  = 10'(HOLD_TICKS);
        nxt_r.start = 1'b1;
        nxt_r.st    = ST_RUN;
      end
      ST_RUN: begin
        if (tick && r_ff.hold != 10'h000) begin
          nxt_r.hold = r_ff.hold - 10'h001;
        end
        // calibration writes refused when locked
        // Lands only on the edge that completes the transfer
        if (pready && pwrite && idx == fcl_pkg::IDX_CTRL && !r_ff.osc[fcl_pkg::OLOCK]) begin
          nxt_r.fcal = pwdata[7:0];
          nxt_r.tcal = pwdata[15:8];
        end
      end
      default: nxt_r.st = ST_LOAD;
    endcase
    if (apb_acc) begin
      // One wait state, then ready for exactly one edge
      nxt_r.ack = !r_ff.ack;
      unique case (idx)
        fcl_pkg::IDX_BOD:   nxt_r.rdata = {24'h000000, r_ff.bod};
        fcl_pkg::IDX_OSC:   nxt_r.rdata = {24'h000000, r_ff.osc};
        fcl_pkg::IDX_SYSA:  nxt_r.rdata = {24'h000000, r_ff.sysa};
        fcl_pkg::IDX_SYSB:  nxt_r.rdata = {24'h000000, r_ff.sysb};
        fcl_pkg::IDX_APPE:  nxt_r.rdata = {24'h000000, r_ff.appe};
        fcl_pkg::IDX_BOOTE: nxt_r.rdata = {24'h000000, r_ff.boote};
        fcl_pkg::IDX_STAT:  nxt_r.rdata = {30'h00000000, startup_done_o,
                                           (r_ff.hold == 10'h000)};
        fcl_pkg::IDX_CTRL:  nxt_r.rdata = {16'h0000, r_ff.tcal, r_ff.fcal};
        default:            nxt_r.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      r_ff.st        <= ST_LOAD;
      r_ff.osc       <= 8'h00;
      r_ff.sysa      <= fcl_pkg::SYSA_RST;
      r_ff.sysb      <= 8'h00;
      r_ff.appe      <= 8'h00;
      r_ff.boote     <= 8'h00;
      r_ff.fcal      <= 8'h00;
      r_ff.tcal      <= 8'h00;
      r_ff.hold      <= 10'h000;
      r_ff.start     <= 1'b0;
      r_ff.ack       <= 1'b0;
      r_ff.rdata     <= 32'h00000000;
      r_ff.bod       <= r_ff.bod;
      r_ff.bod_valid <= r_ff.bod_valid;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // APB: one wait state, unmapped read zero with error
  assign pready  = apb_acc && r_ff.ack;
  assign pslverr = pready && (idx == 4'h0 || idx == 4'h3 || idx == 4'h4 || idx > fcl_pkg::IDX_CTRL
                   || (pwrite && idx != fcl_pkg::IDX_CTRL));
  assign prdata  = r_ff.rdata;

  assign threshold_level_o    = r_ff.bod[fcl_pkg::LVL_HI:fcl_pkg::LVL_LO];
  assign sample_rate_select_o = r_ff.bod[fcl_pkg::SRATE];
  assign bod_active_mode_o    = r_ff.bod[fcl_pkg::ACT_HI:fcl_pkg::ACT_LO];
  assign bod_sleep_mode_o     = (r_ff.bod[fcl_pkg::SLP_HI:fcl_pkg::SLP_LO] == fcl_pkg::SLP_RSVD)
                                ? fcl_pkg::SLP_OFF : r_ff.bod[fcl_pkg::SLP_HI:fcl_pkg::SLP_LO];
  assign calibration_lock_o   = r_ff.osc[fcl_pkg::OLOCK];
  assign osc_20m_select_o     = (fsel_safe == fcl_pkg::FSEL_20M);
  assign main_osc_frequency_cal_o   = r_ff.fcal;
  assign main_osc_temperature_cal_o = r_ff.tcal;
  assign crc_scan_source_o    = r_ff.sysa[fcl_pkg::CRC_HI:fcl_pkg::CRC_LO];
  assign reset_pin_function_o = pin_safe;
  assign gpio_driver_enable_o = (r_ff.st == ST_RUN) && (pin_safe == fcl_pkg::PIN_GPIO)
                                && (r_ff.hold == 10'h000);
  assign erase_eeprom_o = device_locked_i || !r_ff.sysa[fcl_pkg::EEP];

  always_comb begin
    flash_is_boot_o     = 1'b0;
    flash_is_app_code_o = 1'b0;
    flash_is_app_data_o = 1'b0;
    if (r_ff.boote == 8'h00 || blk < {1'b0, r_ff.boote}) begin
      flash_is_boot_o = 1'b1;
    end else if (r_ff.appe == 8'h00 || blk < {1'b0, r_ff.appe}) begin
      flash_is_app_code_o = 1'b1;
    end else begin
      flash_is_app_data_o = 1'b1;
    end
  end

  // chk_pin_hold_gate
  chk_pin_hold_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    gpio_driver_enable_o |-> r_ff.hold == 10'h000) else $error("driver on during hold");
  chk_lock_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (r_ff.st == ST_RUN && calibration_lock_o) |=> $stable(main_osc_frequency_cal_o))
    else $error("locked cal changed");
  chk_erase_locked: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    device_locked_i |-> erase_eeprom_o) else $error("locked erase kept eeprom");
  chk_zero_boot: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (r_ff.boote == 8'h00) |-> flash_is_boot_o) else $error("zero boot end not boot");
  chk_shadow_stable: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (r_ff.st == ST_RUN) |=> $stable(r_ff.sysa) && $stable(r_ff.bod))
    else $error("shadow changed");
  chk_sleep_rsvd: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    bod_sleep_mode_o != fcl_pkg::SLP_RSVD) else $error("reserved sleep mode");
  chk_fsel_20m: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (r_ff.osc[1:0] == fcl_pkg::FSEL_16M) |-> !osc_20m_select_o) else $error("wrong freq");
  chk_app_data: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    flash_is_app_data_o |-> blk >= {1'b0, r_ff.appe} && r_ff.appe != 8'h00)
    else $error("bad data section");
endmodule

// *** rtl/fcl_pkg.sv ***
// Constants for the fuse configuration loader.
// Assumes an APB master with 32-bit data.
package fcl_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [3:0] IDX_BOD   = 4'h1;
  localparam logic [3:0] IDX_OSC   = 4'h2;
  localparam logic [3:0] IDX_SYSA  = 4'h5;
  localparam logic [3:0] IDX_SYSB  = 4'h6;
  localparam logic [3:0] IDX_APPE  = 4'h7;
  localparam logic [3:0] IDX_BOOTE = 4'h8;
  localparam logic [3:0] IDX_STAT  = 4'h9;
  localparam logic [3:0] IDX_CTRL  = 4'ha;
  localparam logic [7:0] SYSA_RST  = 8'hc4;
  // Field positions
  localparam int LVL_HI = 7;
  localparam int LVL_LO = 5;
  localparam int SRATE  = 4;
  localparam int ACT_HI = 3;
  localparam int ACT_LO = 2;
  localparam int SLP_HI = 1;
  localparam int SLP_LO = 0;
  localparam int OLOCK  = 7;
  localparam int FSEL_HI = 1;
  localparam int FSEL_LO = 0;
  localparam int CRC_HI = 7;
  localparam int CRC_LO = 6;
  localparam int PIN_HI = 3;
  localparam int PIN_LO = 2;
  localparam int EEP    = 0;
  localparam int SUT_HI = 2;
  localparam int SUT_LO = 0;
  // Codes
  localparam logic [1:0] FSEL_16M  = 2'h1;
  localparam logic [1:0] FSEL_20M  = 2'h2;
  localparam logic [1:0] PIN_GPIO  = 2'h0;
  localparam logic [1:0] PIN_DEBUG = 2'h1;
  localparam logic [1:0] PIN_RESET = 2'h2;
  localparam logic [1:0] SLP_RSVD  = 2'h3;
  localparam logic [1:0] SLP_OFF   = 2'h0;
  // Timing
  localparam int CLK_HZ      = 125000000;
  localparam int SLOW_HZ     = 32768;
  localparam int SLOW_DIV    = CLK_HZ / SLOW_HZ;
  localparam int PIN_HOLD    = 768;
  localparam int MS_CYCLES   = CLK_HZ / 1000;
endpackage

// *** rtl/fcl_slow_tick.sv ***
// Divider giving one-cycle enables at the slow oscillator rate.
// Assumes one system clock; reset synchronous active low.
`timescale 1ns/1ps
module fcl_slow_tick #(
  parameter int DIV = fcl_pkg::SLOW_DIV
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  output logic      tick_o
);
  initial begin
    if (DIV < 2) $error("DIV too small");
  end
  logic [15:0] cnt_ff;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cnt_ff <= 16'h0000;
    end else if (cnt_ff == 16'(DIV - 1)) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
  assign tick_o = (cnt_ff == 16'(DIV - 1));
endmodule

// *** rtl/fcl_startup.sv ***
// Start-up delay timer: counts the selected number of milliseconds.
// Assumes start_i pulses once when the fuses are latched.
`timescale 1ns/1ps
module fcl_startup #(
  parameter int MS_CYC = fcl_pkg::MS_CYCLES
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       start_i,
  input  wire logic [2:0] sel_i,
  output logic            done_o
);
  initial begin
    if (MS_CYC < 1) $error("MS_CYC too small");
  end
  logic [27:0] cnt_ff;
  logic        run_ff;
  logic        done_ff;
  // Code n>0 means 2^(n-1) ms
  function automatic logic [27:0] span(input logic [2:0] s);
    span = (s == 3'h0) ? 28'h0000000 : 28'(MS_CYC) << (s - 3'h1);
  endfunction
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cnt_ff  <= 28'h0000000;
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
    end else if (start_i) begin
      cnt_ff  <= span(sel_i);
      run_ff  <= 1'b1;
      done_ff <= 1'b0;
    end else if (run_ff) begin
      if (cnt_ff == 28'h0000000) begin
        run_ff  <= 1'b0;
        done_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff - 28'h0000001;
      end
    end
  end
  assign done_o = done_ff;
endmodule

// *** tb/fcl_fuse_model.sv ***
// Fuse storage model: programmed bytes appear on the fuse lines.
// Assumes the bench programs it only while the loader is held in reset.
`timescale 1ns/1ps
module fcl_fuse_model #(
  parameter logic [7:0] CAL16_F = 8'h3a,
  parameter logic [7:0] CAL16_T = 8'h05,
  parameter logic [7:0] CAL20_F = 8'h51,
  parameter logic [7:0] CAL20_T = 8'h0c
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [47:0] prog_i,
  output logic      [47:0] fuse_o,
  output logic      [7:0]  cal16_freq_o,
  output logic      [7:0]  cal16_temp_o,
  output logic      [7:0]  cal20_freq_o,
  output logic      [7:0]  cal20_temp_o
);
  // Bytes only change under reset, so the loader sees stable values
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      fuse_o <= prog_i;
    end
  end
  assign cal16_freq_o = CAL16_F;
  assign cal16_temp_o = CAL16_T;
  assign cal20_freq_o = CAL20_F;
  assign cal20_temp_o = CAL20_T;
endmodule

// *** tb/test_fcl_loader.sv ***
// Self-checking bench for the fuse configuration loader.
// Assumes shortened hold, divider and millisecond parameters.
`timescale 1ns/1ps
module test_fcl_loader;
  logic sys_clk_i, rst_b_i, por, locked, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [47:0] prog, fuse;
  logic [7:0] blk, c16f, c16t, c20f, c20t, lcal, ltemp;
  logic [2:0] lvl;
  logic [1:0] act, slp, crc, pin;
  logic sr, lck, o20, gen, ers, sdone, fb, fa, fd, er;
  int err_count, total_checks, cyc;
  fcl_fuse_model fm (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .prog_i(prog), .fuse_o(fuse),
    .cal16_freq_o(c16f), .cal16_temp_o(c16t), .cal20_freq_o(c20f), .cal20_temp_o(c20t));
  fcl_loader #(.HOLD_TICKS(4), .SLOW_DIV(4), .MS_CYC(10)) dut (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .por_i(por), .fuse_bod_i(fuse[7:0]), .fuse_osc_i(fuse[15:8]),
    .fuse_sysa_i(fuse[23:16]), .fuse_sysb_i(fuse[31:24]), .fuse_appe_i(fuse[39:32]),
    .fuse_boote_i(fuse[47:40]), .cal16_freq_i(c16f), .cal16_temp_i(c16t),
    .cal20_freq_i(c20f), .cal20_temp_i(c20t), .device_locked_i(locked),
    .flash_block_i(blk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .threshold_level_o(lvl), .sample_rate_select_o(sr), .bod_active_mode_o(act),
    .bod_sleep_mode_o(slp), .calibration_lock_o(lck), .osc_20m_select_o(o20),
    .main_osc_frequency_cal_o(lcal), .main_osc_temperature_cal_o(ltemp),
    .crc_scan_source_o(crc), .reset_pin_function_o(pin), .gpio_driver_enable_o(gen),
    .erase_eeprom_o(ers), .startup_done_o(sdone), .flash_is_boot_o(fb),
    .flash_is_app_code_o(fa), .flash_is_app_data_o(fd));
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Reset with optional power-on flag; cyc counts edges until startup done
  task automatic do_reset(input logic p, input logic [47:0] f);
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    por <= p;
    prog <= f;
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    cyc = 0;
    do begin
      @(negedge sys_clk_i);
      cyc++;
    end while (sdone !== 1'b1 && cyc < 200);
    por <= 1'b0;
  endtask
  // Ready, read data and error are taken at the rising edge that completes
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge sys_clk_i);
  endtask
  task automatic t_decode;
    // Bod 5b: lvl 2, 125 Hz, sampled, sleep reserved; osc 16 MHz
    do_reset(1'b1, 48'h02_05_00_41_01_5b);
    chk({lvl, sr, act}, {3'h2, 1'b1, 2'h2});
    chk(slp, 2'h0);
    chk({lck, o20, lcal, ltemp}, {2'b00, c16f, c16t});
    chk({crc, pin, ers}, {2'h1, 2'h0, 1'b0});
    locked <= 1'b1;
    @(negedge sys_clk_i);
    chk(ers, 1'b1);
    locked <= 1'b0;
    $display("test decode done");
  endtask
  task automatic t_bod_reload;
    do_reset(1'b0, 48'h02_05_00_8d_82_e7);
    chk({lvl, sr, act, slp}, 8'h58);
    chk({lck, o20, lcal, crc, pin}, {2'b11, c20f, 2'h2, 2'h2});
    chk(pin, 2'h2);
    do_reset(1'b1, 48'h02_05_00_c4_83_e6);
    chk({lvl, sr, act, slp}, 8'he6);
    chk({o20, crc}, 3'b111);
    $display("test bod reload done");
  endtask
  task automatic t_regs;
    do_reset(1'b1, 48'h06_05_03_d1_02_2a);
    apb(1'b0, 32'h4, 0);
    chk(rd[7:0], 8'h2a);
    apb(1'b0, 32'h20, 0);
    chk({rd[7:0], er}, 9'h00c);
    apb(1'b0, 32'h24, 0);
    chk(rd[1:0], 2'h3);
    apb(1'b1, 32'h14, 32'h00);
    chk(er, 1'b1);
    apb(1'b0, 32'h14, 0);
    chk(rd[7:0], 8'hd1);
    apb(1'b0, 32'h40, 0);
    chk(er, 1'b1);
    apb(1'b1, 32'h28, 32'h7733);
    chk({lcal, ltemp}, 16'h3377);
    do_reset(1'b1, 48'h06_05_03_d1_82_2a);
    apb(1'b1, 32'h28, 32'h1122);
    chk({lcal, ltemp}, {c20f, c20t});
    $display("test registers done");
  endtask
  task automatic t_pin_startup;
    // Pin as GPIO, 4 ms start-up: 40 cycles plus a few
    do_reset(1'b1, 48'h02_05_03_c1_02_00);
    chk(cyc >= 40 && cyc <= 46, 1'b1);
    chk(gen, 1'b1);
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (12) @(negedge sys_clk_i);
    chk(gen, 1'b0);
    repeat (20) @(negedge sys_clk_i);
    chk(gen, 1'b1);
    do_reset(1'b1, 48'h02_05_00_c9_02_00);
    chk(cyc <= 5, 1'b1);
    repeat (40) @(negedge sys_clk_i);
    chk(gen, 1'b0);
    $display("test pin and startup done");
  endtask
  task automatic t_flash;
    logic [47:0] cfg [3];
    logic [2:0] exp [3][3];
    cfg = '{48'h02_05_00_c4_02_00, 48'h02_00_00_c4_02_00, 48'h00_00_00_c4_02_00};
    exp = '{'{3'b100, 3'b010, 3'b001}, '{3'b100, 3'b010, 3'b010}, '{3'b100, 3'b100, 3'b100}};
    for (int i = 0; i < 3; i++) begin
      do_reset(1'b1, cfg[i]);
      for (int j = 0; j < 3; j++) begin
        blk <= (j == 0) ? 8'h01 : (j == 1) ? 8'h03 : 8'h3f;
        @(negedge sys_clk_i);
        chk({fb, fa, fd}, exp[i][j]);
      end
    end
    $display("test flash partition done");
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    report_and_stop();
  end
  initial begin
    {rst_b_i, por, locked, psel, penable, pwrite} = 6'b000000;
    {paddr, pwdata, prog, blk} = '0;
    err_count = 0;
    total_checks = 0;
    t_decode();
    t_bod_reload();
    t_regs();
    t_pin_startup();
    t_flash();
    report_and_stop();
  end
endmodule
